// file: hdl/cpi_pkg.sv
// Purpose: shared constants and types of the coprocessor primitive host sequencer
// Assumes: one clock, coprocessor slot port on the same clock as this logic
// Notes:   slot offsets are byte offsets inside the coprocessor's register set
// How it works
// - opcode word goes to slot 08 on request
// - command word written to slot 0a starts general
// - busy abandons attempt, instruction restarts from start
// - pending interrupts serviced first, then restart
// - breakpoint start plus busy plus interrupt repeats breakpoint
// - control register moves one long word by direction
// - register list primitive moves long words, both categories
// - register list, conditional, come-again clear: protocol violation
// - select mask low byte data, high byte address
// - order data seven to zero, then address
// - direction picks write-out or read-in per register
// - coprocessor list moves zero to sixteen operands
// - coprocessor list in conditional: protocol violation
// - odd operand length: protocol violation
package cpi_pkg;

  // slot offsets inside the coprocessor register set
  localparam logic [4:0] OFF_RESP    = 5'h00;  // response slot
  localparam logic [4:0] OFF_OPWORD  = 5'h08;  // opcode_word_slot
  localparam logic [4:0] OFF_CMD     = 5'h0a;  // command_word_slot
  localparam logic [4:0] OFF_COND    = 5'h0e;  // condition slot
  localparam logic [4:0] OFF_OPERAND = 5'h10;  // operand slot, long words
  localparam logic [4:0] OFF_SELECT  = 5'h14;  // transfer_select_mask

  // response word field positions
  localparam int BIT_COME_AGAIN = 15;  // come_again_flag
  localparam int BIT_PC_PASS    = 14;  // pc_pass_flag
  localparam int BIT_DIR        = 13;  // transfer_direction_flag
  localparam int KIND_HI        = 12;  // primitive kind field, top bit
  localparam int KIND_LO        = 8;   // primitive kind field, low bit

  // primitive kinds held in bits 12..8
  localparam logic [4:0] KIND_MREG = 5'h06;  // data/address register list
  localparam logic [4:0] KIND_MCR  = 5'h01;  // coprocessor register list
  localparam logic [4:0] KIND_BUSY = 5'h10;  // busy
  localparam logic [4:0] KIND_OPW  = 5'h11;  // transfer opcode word
  localparam logic [4:0] KIND_CTL  = 5'h12;  // single control register

  localparam logic [15:0] RST_WORD = 16'h0000;  // reset of held words
  localparam int          IDX_W    = 12;        // register reference width
  localparam int          FIFO_D   = 8;         // inbound operand fifo depth

  // sequencer states, gray along the usual path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_START = 4'h1, S_RESP = 4'h3, S_DISP = 4'h2,
    S_SEL  = 4'h6, S_PICK  = 4'h7, S_CHK  = 4'h5, S_PUT  = 4'h4,
    S_GET  = 4'hc, S_NEXT  = 4'hd, S_OPW  = 4'hf, S_IRQ  = 4'he
  } cpi_state_type;

  // how an instruction ended
  typedef enum logic [2:0] {
    ST_OK = 3'h0, ST_PROTO = 3'h1, ST_FLINE = 3'h2, ST_EA = 3'h3, ST_OTHER = 3'h4
  } cpi_status_type;

  typedef struct packed {
    logic        cond;     // conditional category when set
    logic        brk;      // started by a breakpoint acknowledge cycle
    logic [15:0] opcode;   // instruction opcode word
    logic [15:0] cmdword;  // command or condition word
  } cpi_cmd_type;

  typedef struct packed {
    logic        req;      // held until ack
    logic        wr;       // write when set
    logic        long_op;  // long word access when set
    logic [4:0]  addr;     // slot offset
    logic [31:0] wdata;    // write data, words in low half
  } cpi_cir_type;

  typedef struct packed {
    logic             ctl;  // control register when set
    logic [IDX_W-1:0] idx;  // 0..7 data, 8..15 address, or control code
  } cpi_ref_type;

  typedef struct packed {
    cpi_ref_type dst;   // destination register
    logic [31:0] data;  // long word operand
  } cpi_wb_type;

  typedef struct packed {
    cpi_status_type status;  // end reason
    logic [15:0]    prim;    // last primitive word
    logic [4:0]     count;   // operands to move for the address engine
    logic [7:0]     len;     // operand byte length
  } cpi_result_type;

endpackage

// file: hdl/cpi_pick.sv
// Purpose: finds the highest set bit of a group
// Assumes: W is a power of two
// Notes:   purely combinational
`timescale 1ns/10ps
module cpi_pick #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         bits_i,   // candidate bits
  output logic                      found_o,  // any bit set
  output logic [$clog2(W)-1:0]      idx_o     // highest set position
);
  // ascending scan so the highest set bit wins
  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    for (int i = 0; i < W; i++) begin
      if (bits_i[i]) begin
        found_o = 1'b1;
        idx_o   = ($clog2(W))'(i);
      end
    end
  end
endmodule // cpi_pick

// file: hdl/cpi_fifo.sv
// Purpose: small operand fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   out_data is the head entry, valid while out_valid is high
`timescale 1ns/10ps
module cpi_fifo #(
  parameter int W     = 45,
  parameter int DEPTH = 8
) (
  input  wire logic         mclk_i,       // clock
  input  wire logic         rst_i,        // async reset, high
  input  wire logic         in_valid_i,   // push request
  output logic              in_ready_o,   // room left
  input  wire logic [W-1:0] in_data_i,    // pushed word
  output logic              out_valid_o,  // head present
  input  wire logic         out_ready_i,  // pop request
  output logic [W-1:0]      out_data_o    // head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // storage
    logic [AW-1:0]           wp;   // write pointer
    logic [AW-1:0]           rp;   // read pointer
    logic [AW:0]             cnt;  // entries held
  } cpi_fifo_type;

  cpi_fifo_type st, next_st;
  logic         push, pop;

  assign in_ready_o  = st.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = st.cnt != '0;
  assign out_data_o  = st.mem[st.rp];

  // pointer and count update; push and pop may share a cycle
  always_comb begin
    next_st = st;
    push    = in_valid_i && in_ready_o;
    pop     = out_ready_i && out_valid_o;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // cpi_fifo

// file: hdl/cpi_host.sv
// Purpose: processor-side sequencer that starts coprocessor instructions and
//          serves the busy, opcode-word and register transfer primitives
// Assumes: the slot port and the core register file share mclk_i
// Notes:   coprocessor list transfers are handed to the address engine
`timescale 1ns/10ps
module cpi_host
  import cpi_pkg::*;
(
  input  wire logic                    mclk_i,         // 20 MHz clock
  input  wire logic                    rst_i,          // async reset, high
  input  wire logic                    start_i,        // begin an instruction
  input  wire cpi_pkg::cpi_cmd_type    cmd_i,          // instruction taken on start
  output cpi_pkg::cpi_cmd_type         cmd_o,          // instruction held
  output logic                         active_o,       // sequencer not idle
  input  wire logic                    irq_pending_i,  // core has an interrupt waiting
  input  wire logic                    irq_done_i,     // core finished interrupt entry
  output logic                         irq_take_o,     // core must service interrupts
  output logic                         brk_repeat_o,   // rerun breakpoint acknowledge
  output cpi_pkg::cpi_cir_type         cir_o,          // slot access request
  input  wire logic                    cir_ack_i,      // slot access done
  input  wire logic [31:0]             cir_rdata_i,    // slot read data
  output cpi_pkg::cpi_ref_type         rd_ref_o,       // register to read
  input  wire logic [31:0]             rd_data_i,      // its value, same cycle
  input  wire logic                    rd_bad_i,       // control code not valid
  output cpi_pkg::cpi_wb_type          wr_o,           // register write-back
  output logic                         wr_valid_o,     // write-back present
  input  wire logic                    wr_ready_i,     // core takes write-back
  output logic                         done_o,         // end pulse
  output cpi_pkg::cpi_result_type      result_o        // end report
);
  import cpi_pkg::*;

  typedef struct packed {
    cpi_state_type  state;     // sequencer state
    logic           active;    // mirror of state != idle
    cpi_cmd_type    ins;       // instruction in progress
    cpi_cir_type    coproc_iface_register;       // slot request
    logic [15:0]    prim;      // last primitive word
    logic [15:0]    mask;      // registers still to move
    cpi_ref_type    rd_ref;    // register being moved
    logic           irq_take;  // interrupt service request
    logic           brk_rep;   // breakpoint repeat pulse
    logic           done;      // end pulse
    cpi_result_type res;       // end report
    logic           wr_valid;  // write-back stage full
    cpi_wb_type     wr;        // write-back stage
  } cpi_host_type;

  cpi_host_type   st, next;
  logic           fifo_push, fifo_in_ready, fifo_out_valid, wb_take;
  cpi_wb_type     fifo_in, fifo_out;
  logic           d_found, a_found, fin_now;
  logic [2:0]     d_idx, a_idx;
  logic [3:0]     pidx;
  logic [4:0]     kind;
  logic           ca, dr;
  cpi_status_type fin_code;

  // slot request builder
  function automatic cpi_cir_type slot_op(input logic wr, input logic lng,
                                          input logic [4:0] addr, input logic [31:0] data);
    cpi_cir_type c;
    c.req     = 1'b1;
    c.wr      = wr;
    c.long_op = lng;
    c.addr    = addr;
    c.wdata   = data;
    return c;
  endfunction

  // write that starts or restarts an instruction
  function automatic cpi_cir_type start_op(input cpi_cmd_type c);
    return slot_op(1'b1, 1'b0, c.cond ? OFF_COND : OFF_CMD, {16'h0000, c.cmdword});
  endfunction

  // inbound operands queue here so a slow register file stalls the slot reads only once eight are held
  cpi_fifo #(
    .W     ($bits(cpi_wb_type)),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (wb_take),
    .out_data_o  (fifo_out)
  );

  // highest selected data register first, then address registers
  cpi_pick #(.W(8)) u_pick_d (.bits_i(st.mask[7:0]),  .found_o(d_found), .idx_o(d_idx));
  cpi_pick #(.W(8)) u_pick_a (.bits_i(st.mask[15:8]), .found_o(a_found), .idx_o(a_idx));

  assign pidx = d_found ? {1'b0, d_idx} : {1'b1, a_idx};
  assign kind = st.prim[KIND_HI:KIND_LO];
  assign ca   = st.prim[BIT_COME_AGAIN];
  assign dr   = st.prim[BIT_DIR];

  // next-state calculation for the whole sequencer
  always_comb begin
    next      = st;
    next.done    = 1'b0;
    next.brk_rep = 1'b0;
    fifo_push = 1'b0;
    fifo_in   = '{dst: st.rd_ref, data: cir_rdata_i};
    fin_now   = 1'b0;
    fin_code  = ST_OK;
    // write-back stage drains the fifo one entry per accepted word
    wb_take = fifo_out_valid && (!st.wr_valid || wr_ready_i);
    if (st.wr_valid && wr_ready_i) begin
      next.wr_valid = 1'b0;
    end
    if (wb_take) begin
      next.wr_valid = 1'b1;
      next.wr       = fifo_out;
    end
    // a slot request stays up until acknowledged
    if (cir_ack_i) begin
      next.coproc_iface_register.req = 1'b0;
    end
    unique case (st.state)
      S_IDLE: begin
        if (start_i) begin
          next.ins   = cmd_i;
          next.coproc_iface_register   = start_op(cmd_i);
          next.state = S_START;
        end
      end
      S_START: begin
        if (cir_ack_i) begin
          next.coproc_iface_register   = slot_op(1'b0, 1'b0, OFF_RESP, 32'h0000_0000);
          next.state = S_RESP;
        end
      end
      S_RESP: begin
        if (cir_ack_i) begin
          next.prim  = cir_rdata_i[15:0];
          next.state = S_DISP;
        end
      end
      S_DISP: begin
        // decode the primitive kind; unknown kinds go back to the core
        if (kind == KIND_BUSY) begin
          if (irq_pending_i) begin
            next.irq_take = 1'b1;
            next.state    = S_IRQ;
          end else begin
            next.coproc_iface_register   = start_op(st.ins);
            next.state = S_START;
          end
        end else if (kind == KIND_OPW) begin
          next.coproc_iface_register   = slot_op(1'b1, 1'b0, OFF_OPWORD, {16'h0000, st.ins.opcode});
          next.state = S_OPW;
        end else if (kind == KIND_CTL) begin
          next.rd_ref.ctl = 1'b1;
          next.coproc_iface_register        = slot_op(1'b0, 1'b0, OFF_SELECT, 32'h0000_0000);
          next.state      = S_SEL;
        end else if (kind == KIND_MREG && st.prim[7:0] == 8'h00) begin
          if (st.ins.cond && !ca) begin
            fin_now  = 1'b1;
            fin_code = ST_PROTO;
          end else begin
            next.rd_ref.ctl = 1'b0;
            next.coproc_iface_register        = slot_op(1'b0, 1'b0, OFF_SELECT, 32'h0000_0000);
            next.state      = S_SEL;
          end
        end else if (kind == KIND_MCR) begin
          if (st.ins.cond || st.prim[0]) begin
            fin_now  = 1'b1;
            fin_code = ST_PROTO;
          end else begin
            next.coproc_iface_register   = slot_op(1'b0, 1'b0, OFF_SELECT, 32'h0000_0000);
            next.state = S_SEL;
          end
        end else begin
          fin_now  = 1'b1;
          fin_code = ST_OTHER;
        end
      end
      S_OPW: begin
        if (cir_ack_i) begin
          next.state = S_NEXT;
        end
      end
      S_SEL: begin
        if (cir_ack_i) begin
          if (kind == KIND_MCR) begin
            next.res.count = 5'($countones(cir_rdata_i[15:0]));
            next.res.len   = st.prim[7:0];
            fin_now        = 1'b1;
            fin_code       = ST_EA;
          end else if (st.rd_ref.ctl) begin
            next.rd_ref.idx = cir_rdata_i[IDX_W-1:0];
            next.state      = S_CHK;
          end else begin
            next.mask  = cir_rdata_i[15:0];
            next.state = S_PICK;
          end
        end
      end
      S_PICK: begin
        if (!d_found && !a_found) begin
          next.state = S_NEXT;
        end else begin
          next.rd_ref.idx  = {8'h00, pidx};
          next.mask[pidx]  = 1'b0;
          next.state       = S_CHK;
        end
      end
      S_CHK: begin
        // register index settled last cycle, so rd_data_i is its value now
        if (st.rd_ref.ctl && rd_bad_i) begin
          fin_now  = 1'b1;
          fin_code = ST_FLINE;
        end else if (!dr) begin
          next.coproc_iface_register   = slot_op(1'b1, 1'b1, OFF_OPERAND, rd_data_i);
          next.state = S_PUT;
        end else if (fifo_in_ready) begin
          next.coproc_iface_register   = slot_op(1'b0, 1'b1, OFF_OPERAND, 32'h0000_0000);
          next.state = S_GET;
        end
      end
      S_PUT: begin
        if (cir_ack_i) begin
          next.state = st.rd_ref.ctl ? S_NEXT : S_PICK;
        end
      end
      S_GET: begin
        // only one read is ever outstanding, so the room checked stays free
        if (cir_ack_i) begin
          fifo_push  = 1'b1;
          next.state = st.rd_ref.ctl ? S_NEXT : S_PICK;
        end
      end
      S_NEXT: begin
        if (ca) begin
          next.coproc_iface_register   = slot_op(1'b0, 1'b0, OFF_RESP, 32'h0000_0000);
          next.state = S_RESP;
        end else begin
          fin_now  = 1'b1;
          fin_code = ST_OK;
        end
      end
      S_IRQ: begin
        // restart only after interrupt entry; breakpoint start reruns the cycle
        if (irq_done_i) begin
          next.irq_take = 1'b0;
          next.brk_rep  = st.ins.brk;
          next.coproc_iface_register      = start_op(st.ins);
          next.state    = S_START;
        end
      end
      default: begin
        next.state = S_IDLE;
      end
    endcase
    if (fin_now) begin
      next.done       = 1'b1;
      next.res.status = fin_code;
      next.res.prim   = st.prim;
      next.state      = S_IDLE;
    end
    next.active = next.state != S_IDLE;
  end

  // single register for all state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next;
    end
  end

  assign cmd_o        = st.ins;
  assign active_o     = st.active;
  assign irq_take_o   = st.irq_take;
  assign brk_repeat_o = st.brk_rep;
  assign cir_o        = st.coproc_iface_register;
  assign rd_ref_o     = st.rd_ref;
  assign wr_o         = st.wr;
  assign wr_valid_o   = st.wr_valid;
  assign done_o       = st.done;
  assign result_o     = st.res;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  opword_data_a: assert property (st.coproc_iface_register.req && st.coproc_iface_register.wr && st.coproc_iface_register.addr == OFF_OPWORD
    |-> st.coproc_iface_register.wdata[15:0] == st.ins.opcode && st.state == S_OPW)
    else $error("opcode slot write carries the wrong word");
  cmd_write_a: assert property (st.state == S_IDLE && start_i && !cmd_i.cond
    |=> st.coproc_iface_register.req && st.coproc_iface_register.wr && st.coproc_iface_register.addr == OFF_CMD && st.coproc_iface_register.wdata[15:0] == $past(cmd_i.cmdword))
    else $error("command word not written to command slot");
  busy_restart_a: assert property (st.state == S_DISP && kind == KIND_BUSY && !irq_pending_i
    |=> st.state == S_START && st.coproc_iface_register.req && !done_o)
    else $error("busy did not restart the instruction");
  irq_first_a: assert property (st.state == S_DISP && kind == KIND_BUSY && irq_pending_i
    |=> irq_take_o && !st.coproc_iface_register.req ##1 (irq_take_o || st.state == S_START))
    else $error("interrupts not serviced before restart");
  brk_repeat_a: assert property (brk_repeat_o
    |-> $past(st.state) == S_IRQ && $past(irq_done_i) && st.ins.brk && st.state == S_START)
    else $error("breakpoint repeat without busy and interrupt");
  ctl_out_a: assert property (st.state == S_CHK && st.rd_ref.ctl && !rd_bad_i && !dr
    |=> st.coproc_iface_register.wr && st.coproc_iface_register.long_op && st.coproc_iface_register.addr == OFF_OPERAND && st.coproc_iface_register.wdata == $past(rd_data_i))
    else $error("control register not written as long word");
  pick_order_a: assert property (st.state == S_PICK && st.mask != 16'h0000
    |=> st.rd_ref.idx[3] == ($past(st.mask[7:0]) == 8'h00)
        && ((st.rd_ref.idx[3] ? $past(st.mask[15:8]) : $past(st.mask[7:0])) >> st.rd_ref.idx[2:0]) == 8'h01)
    else $error("register moved out of order");
  mreg_proto_a: assert property (st.state == S_DISP && kind == KIND_MREG && st.ins.cond && !ca
    |=> done_o && result_o.status == ST_PROTO)
    else $error("conditional list without come-again not refused");
  mcr_proto_a: assert property (st.state == S_DISP && kind == KIND_MCR && (st.ins.cond || st.prim[0])
    |=> done_o && result_o.status == ST_PROTO && !st.coproc_iface_register.req)
    else $error("coprocessor list not refused");
  get_push_a: assert property (st.state == S_GET && cir_ack_i
    |-> fifo_push && fifo_in_ready && fifo_in.data == cir_rdata_i && fifo_in.dst == st.rd_ref)
    else $error("operand read not queued");

endmodule // cpi_host

// file: bench/cpi_copro_model.sv
// Purpose: coprocessor slave model answering the host's slot accesses
// Assumes: same clock as the host; ack comes delay cycles after req is seen
// Notes:   the bench queues responses, mask and operands, and reads wlog
`timescale 1ns/10ps
module cpi_copro_model
  import cpi_pkg::*;
(
  input  wire logic                 mclk_i,  // clock
  input  wire logic                 rst_i,   // async reset, high
  input  wire cpi_pkg::cpi_cir_type cir_i,   // slot request from the host
  output logic                      ack_o,   // one-cycle completion
  output logic [31:0]               rdata_o  // read data, valid with ack_o
);
  import cpi_pkg::*;
  logic [15:0] resp_q[$];   // served in order; busy only ever queued first
  logic [15:0] sel;         // select register contents
  logic [31:0] opnd_q[$];   // operand slot read data
  logic [37:0] wlog[$];     // writes seen: long flag, offset, data
  int          delay = 0;   // wait states, raised to answer slowly
  int          cnt;         // wait state counter

  // answer after the wait states; ack_o high skips one cycle so a held
  // back-to-back request is never acked twice
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      cnt     <= 0;
      rdata_o <= 32'h0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;  // stale data flips so it never passes for an answer
      if (cir_i.req && !ack_o) begin
        if (cnt < delay) begin
          cnt <= cnt + 1;
        end else begin
          cnt   <= 0;
          ack_o <= 1'b1;
          if (cir_i.wr) begin
            wlog.push_back({cir_i.long_op, cir_i.addr, cir_i.wdata});
          end else if (cir_i.addr == OFF_RESP) begin
            rdata_o <= {16'h0, resp_q.pop_front()};
          end else if (cir_i.addr == OFF_SELECT) begin
            rdata_o <= {16'h0, sel};
          end else begin
            rdata_o <= opnd_q.pop_front();
          end
        end
      end
    end
  end
endmodule // cpi_copro_model

// file: bench/cpi_host_tb_top.sv
// Purpose: self-checking bench of the coprocessor primitive host
// Assumes: slot partner is cpi_copro_model; core registers modelled here
// Notes:   a core register reads as a tag byte plus its index
`timescale 1ns/10ps
module cpi_host_tb_top;
  import cpi_pkg::*;
  logic           mclk_i = 0, rst_i = 1, start_i = 0;                  // clock, reset, start
  logic           irq_pending_i = 0, irq_done_i = 0, wr_ready_i = 1;   // core side inputs
  logic           active_o, irq_take_o, brk_repeat_o, cir_ack_i, wr_valid_o, done_o, rd_bad_i;
  logic [31:0]    cir_rdata_i, rd_data_i;                               // slot and register data
  cpi_cmd_type    cmd_i = '0, cmd_o;                                    // instruction in and held
  cpi_cir_type    cir_o;                                                // slot request
  cpi_ref_type    rd_ref_o;                                             // register being read
  cpi_wb_type     wr_o;                                                 // write-back
  cpi_result_type result_o;                                             // end report
  cpi_wb_type     wb_q[$];                                              // write-backs taken
  int             bad_count = 0, tests_run = 0, cyc = 0, irqs = 0, brks = 0, k;

  // core register contents: control registers get a different tag
  function automatic logic [31:0] regv(input logic ctl, input logic [11:0] idx);
    return {ctl ? 8'hc7 : 8'ha5, 12'h000, idx};
  endfunction
  assign rd_data_i = regv(rd_ref_o.ctl, rd_ref_o.idx);
  assign rd_bad_i  = rd_ref_o.ctl && (rd_ref_o.idx == 12'hfff);  // only code fff is rejected

  always #25 mclk_i = ~mclk_i;

  cpi_host u_cpi_host (.mclk_i, .rst_i, .start_i, .cmd_i, .cmd_o, .active_o, .irq_pending_i,
    .irq_done_i, .irq_take_o, .brk_repeat_o, .cir_o, .cir_ack_i, .cir_rdata_i, .rd_ref_o,
    .rd_data_i, .rd_bad_i, .wr_o, .wr_valid_o, .wr_ready_i, .done_o, .result_o);
  cpi_copro_model u_cpi_copro_model (.mclk_i, .rst_i, .cir_i(cir_o), .ack_o(cir_ack_i),
    .rdata_o(cir_rdata_i));

  // core side: stalls write-back most of the time, answers interrupt entry, watchdog
  always @(posedge mclk_i) begin
    cyc        <= cyc + 1;
    wr_ready_i <= (cyc % 40) < 10;
    irq_done_i <= irq_take_o && !irq_done_i;
    if (irq_take_o && !irq_done_i) irqs <= irqs + 1;
    if (brk_repeat_o) brks <= brks + 1;
    if (wr_valid_o && wr_ready_i) wb_q.push_back(wr_o);
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // i-th slot write; word slots compare only the low half
  task automatic logw(input int i, input logic [4:0] a, input logic [31:0] d);
    logic [37:0] e;
    e = u_cpi_copro_model.wlog[i];
    if (a != OFF_OPERAND) e[31:16] = 16'h0000;
    chk(e, {a == OFF_OPERAND, a, d});
  endtask

  task automatic wbw(input int n);
    for (int t = 0; t < 2000 && wb_q.size() < n; t++) @(negedge mclk_i);
  endtask

  // one instruction: start held for one edge, then wait for the end pulse
  task automatic run(input logic cond, brk, input logic [15:0] cw, input cpi_status_type st);
    int n;
    n = 0;
    u_cpi_copro_model.wlog.delete();
    wb_q.delete();
    @(posedge mclk_i);
    start_i <= 1'b1;
    cmd_i   <= '{cond, brk, 16'hf240, cw};
    @(posedge mclk_i);
    start_i <= 1'b0;
    while (done_o !== 1'b1 && n < 500) begin
      @(negedge mclk_i);
      n++;
    end
    chk({done_o, result_o.status}, {1'b1, st});
    chk({active_o, cmd_o}, {1'b0, cond, brk, 16'hf240, cw});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk({active_o, cir_o.req}, 2'b00);
    u_cpi_copro_model.resp_q = '{16'h0600};
    u_cpi_copro_model.sel = 16'h0180;
    run(1'b0, 1'b0, 16'h4a21, ST_OK);
    logw(0, OFF_CMD, 32'h4a21);
    logw(1, OFF_OPERAND, regv(1'b0, 12'h007));
    logw(2, OFF_OPERAND, regv(1'b0, 12'h008));
    chk(u_cpi_copro_model.wlog.size(), 3);
    $display("test list out done");
    u_cpi_copro_model.resp_q = '{16'h8600, 16'h1100};
    u_cpi_copro_model.sel = 16'h0001;
    run(1'b1, 1'b0, 16'h0005, ST_OK);
    logw(0, OFF_COND, 32'h5);
    logw(1, OFF_OPERAND, regv(1'b0, 12'h000));
    logw(2, OFF_OPWORD, 32'hf240);
    u_cpi_copro_model.resp_q = '{16'h0600};
    run(1'b1, 1'b0, 16'h0005, ST_PROTO);
    $display("test conditional list done");
    // slow slot and stalled core: inbound operands queue in the fifo while write-back stalls
    u_cpi_copro_model.delay = 2;
    u_cpi_copro_model.sel = 16'hffff;
    u_cpi_copro_model.resp_q = '{16'h2600};
    for (k = 0; k < 16; k++) u_cpi_copro_model.opnd_q.push_back(32'h10000000 + k);
    run(1'b0, 1'b0, 16'h0007, ST_OK);
    wbw(16);
    for (k = 0; k < 16; k++) chk({wb_q[k].dst, wb_q[k].data}, {1'b0, 12'(k < 8 ? 7 - k : 23 - k), 32'h10000000 + k});
    u_cpi_copro_model.delay = 0;
    $display("test list in done");
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk_i);
      irq_pending_i <= p[0];
      u_cpi_copro_model.resp_q = '{16'h1000, 16'h1100};
      run(1'b0, 1'b1, 16'h0100, ST_OK);
      chk({irqs[3:0], brks[3:0]}, {p[3:0], p[3:0]});
      logw(1, OFF_CMD, 32'h0100);
    end
    $display("test busy done");
    u_cpi_copro_model.resp_q = '{16'h1200};
    u_cpi_copro_model.sel = 16'h0003;
    run(1'b0, 1'b0, 16'h0009, ST_OK);
    logw(1, OFF_OPERAND, regv(1'b1, 12'h003));
    u_cpi_copro_model.resp_q = '{16'h3200};
    u_cpi_copro_model.sel = 16'h0005;
    u_cpi_copro_model.opnd_q = '{32'h5a5a0001};
    run(1'b0, 1'b0, 16'h0009, ST_OK);
    wbw(1);
    chk({wb_q[0].dst, wb_q[0].data}, {1'b1, 12'h005, 32'h5a5a0001});
    u_cpi_copro_model.resp_q = '{16'h1200};
    u_cpi_copro_model.sel = 16'h0fff;
    run(1'b0, 1'b0, 16'h0009, ST_FLINE);
    $display("test control done");
    u_cpi_copro_model.sel = 16'h00f0;
    for (int j = 0; j < 3; j++) begin
      u_cpi_copro_model.resp_q = '{j == 1 ? 16'h0103 : 16'h0102};
      run(j == 2, 1'b0, 16'h000b, j == 0 ? ST_EA : ST_PROTO);
      if (j == 0) chk({result_o.count, result_o.len}, {5'h04, 8'h02});
    end
    u_cpi_copro_model.resp_q = '{16'h0607};
    run(1'b0, 1'b0, 16'h000d, ST_OTHER);
    chk(result_o.prim, 16'h0607);
    $display("test coprocessor list done");
    conclude();
  end
endmodule // cpi_host_tb_top
